// file: sar_conversion_sequencer.v
// Contract
// R1 - rising edge of conversion start ends acquisition, begins conversion
// R2 - open both ground switches first, then ground the arrays holding sample
// R3 - sixteen binary-weighted trials, MSB first, halving weights
// R4 - after last decision return to acquisition, form code, signal done via busy
// R5 - conversion timed by internal clock, independent of serial clock
// R6 - unipolar modes give straight binary output
// R7 - bipolar modes give twos complement output
// R8 - overrange input saturates at highest code of active format
// R9 - underrange input saturates at lowest code of active format
// R10 - configuration bit six selects full or quarter input bandwidth
// R11 - host slows conversion rate by four in quarter bandwidth; the testbench host stretches the period from 59 to 209 cycles
// R12 - options come from a fourteen-bit configuration word
// R13 - input configuration field selects unipolar or bipolar coding
// R14 - each result belongs to the conversion just done, no latency
// R15 - busy high from start edge until result readable
`include "sar_defs.vh"
module sar_conversion_sequencer (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // host side
    input  wire                 conversion_start_input_i,
    input  wire [`CFG_W-1:0]    cfg_word_i,
    // analog front end
    input  wire                 comparator_i,
    input  wire                 over_range_i,
    input  wire                 under_range_i,
    output reg                  positive_array_ground_switch_o,
    output reg                  negative_array_ground_switch_o,
    output reg                  array_to_inputs_o,
    output reg  [`RES_W-1:0]    dac_bits_o,
    output reg                  quarter_bw_o,
    // result
    output reg  [`RES_W-1:0]    result_o,
    output reg                  busy_o,
    output reg                  result_valid_o
);

localparam ST_ACQ  = 3'h0;
localparam ST_OPEN = 3'h1;
localparam ST_HOLD = 3'h2;
localparam ST_BIT  = 3'h3;
localparam ST_DONE = 3'h4;

// R13 coding select
function is_bipolar;
    input [2:0] incc;
    begin
        is_bipolar = (incc == `INCC_BIP_COM) || (incc[2:1] == 2'h0);
    end
endfunction

// R3 retire trial bit with its decision, raise the next lower one
function [`RES_W-1:0] trial_next;
    input [`RES_W-1:0] pattern;
    input [3:0]        idx;
    input              keep;
    reg   [`RES_W-1:0] one_hot;
    begin
        one_hot    = {{(`RES_W-1){1'b0}}, 1'b1} << idx;
        // shift right, so the lsb trial raises nothing below it
        trial_next = (pattern & ~one_hot) | (keep ? one_hot : {`RES_W{1'b0}})
                     | (one_hot >> 1);
    end
endfunction

// R8 R9 clamps win over the raw code; overrange wins over underrange
function [`RES_W-1:0] coded_result;
    input [`RES_W-1:0] raw;
    input              bip;
    input              ovr;
    input              und;
    begin
        if (ovr) begin
            coded_result = bip ? `BIP_MAX : `UNI_MAX;
        end else if (und) begin
            coded_result = bip ? `BIP_MIN : `UNI_MIN;
        end else begin
            // R6 R7 straight binary or twos complement
            coded_result = bip ? (raw ^ `SIGN_FLIP) : raw;
        end
    end
endfunction

// pins are async to clk_i, two flops each
reg  [1:0]          cnv_sync_r;
reg                 cnv_prev_r;
reg  [1:0]          cmp_sync_r;
reg  [1:0]          ovr_sync_r;
reg  [1:0]          und_sync_r;
// config word is quasi-static; only read while acquiring
reg  [`CFG_W-1:0]   cfg_meta_r;
reg  [`CFG_W-1:0]   cfg_sync_r;
reg  [2:0]          state_r;
reg  [1:0]          wait_r;
reg  [`STEP_W-1:0]  step_r;
reg  [`RES_W-1:0]   sar_r;
reg                 bip_r;

wire cnv_rise = cnv_sync_r[1] & ~cnv_prev_r;
wire [3:0] bit_idx = `MSB_IDX - step_r[3:0];

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        cnv_sync_r <= 2'h0;
        cnv_prev_r <= 1'b0;
        cmp_sync_r <= 2'h0;
        ovr_sync_r <= 2'h0;
        und_sync_r <= 2'h0;
        cfg_meta_r <= {`CFG_W{1'b0}};
        cfg_sync_r <= {`CFG_W{1'b0}};
    end else begin
        cnv_sync_r <= {cnv_sync_r[0], conversion_start_input_i};
        cnv_prev_r <= cnv_sync_r[1];
        cmp_sync_r <= {cmp_sync_r[0], comparator_i};
        ovr_sync_r <= {ovr_sync_r[0], over_range_i};
        und_sync_r <= {und_sync_r[0], under_range_i};
        // R12 configuration word through two flops
        cfg_meta_r <= cfg_word_i;
        cfg_sync_r <= cfg_meta_r;
    end
end

// R5 all sequencing on internal clock
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_r                        <= ST_ACQ;
        wait_r                         <= 2'h0;
        step_r                         <= {`STEP_W{1'b0}};
        sar_r                          <= {`RES_W{1'b0}};
        bip_r                          <= 1'b0;
        positive_array_ground_switch_o <= 1'b1;
        negative_array_ground_switch_o <= 1'b1;
        array_to_inputs_o              <= 1'b1;
        dac_bits_o                     <= {`RES_W{1'b0}};
        quarter_bw_o                   <= 1'b0;
        result_o                       <= `UNI_MIN;
        busy_o                         <= 1'b0;
        result_valid_o                 <= 1'b0;
    end else begin
        case (state_r)
            ST_ACQ: begin
                // R10 R12 filter bit, held fixed during conversion
                quarter_bw_o <= cfg_sync_r[`CFG_BW_BIT];
                // R1 start edge
                if (cnv_rise) begin
                    // R13 latch coding for this sample
                    bip_r <= is_bipolar(cfg_sync_r[`CFG_INCC_HI:`CFG_INCC_LO]);
                    // R2 ground switches open first
                    positive_array_ground_switch_o <= 1'b0;
                    negative_array_ground_switch_o <= 1'b0;
                    // R15 busy from start edge
                    busy_o         <= 1'b1;
                    result_valid_o <= 1'b0;
                    wait_r         <= `GND_OPEN_CYC;
                    state_r        <= ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (wait_r == `WAIT_LAST) begin
                    // R2 then arrays to ground, sample held
                    array_to_inputs_o <= 1'b0;
                    wait_r            <= `HOLD_CYC;
                    state_r           <= ST_HOLD;
                end else begin
                    wait_r <= wait_r - 2'h1;
                end
            end
            ST_HOLD: begin
                if (wait_r == `WAIT_LAST) begin
                    // R3 first trial at msb
                    wait_r     <= `TRIAL_CYC;
                    step_r     <= {`STEP_W{1'b0}};
                    sar_r      <= {`RES_W{1'b0}};
                    dac_bits_o <= `SIGN_FLIP;
                    state_r    <= ST_BIT;
                end else begin
                    wait_r <= wait_r - 2'h1;
                end
            end
            ST_BIT: begin
                // R3 hold each trial until its decision has crossed the sync
                // comparator settles two flops late; trade speed for safety
                if (wait_r != `WAIT_LAST) begin
                    wait_r <= wait_r - 2'h1;
                end else begin
                    // R3 keep trial bit if comparator says input above dac
                    sar_r[bit_idx] <= cmp_sync_r[1];
                    if (step_r == `STEP_LAST) begin
                        state_r <= ST_DONE;
                    end else begin
                        dac_bits_o <= trial_next(dac_bits_o, bit_idx, cmp_sync_r[1]);
                        step_r     <= step_r + 5'h01;
                        wait_r     <= `TRIAL_CYC;
                    end
                end
            end
            ST_DONE: begin
                // R4 back to acquisition
                positive_array_ground_switch_o <= 1'b1;
                negative_array_ground_switch_o <= 1'b1;
                array_to_inputs_o              <= 1'b1;
                dac_bits_o                     <= {`RES_W{1'b0}};
                // R8 R9 saturate, R6 R7 coding, R14 this sample only
                result_o <= coded_result(sar_r, bip_r, ovr_sync_r[1], und_sync_r[1]);
                // R15 busy drops with result readable
                busy_o         <= 1'b0;
                result_valid_o <= 1'b1;
                state_r        <= ST_ACQ;
            end
            default: begin
                state_r <= ST_ACQ;
            end
        endcase
    end
end

endmodule

// file: sar_conversion_sequencer_asserts.sv
module sar_seq_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        conversion_start_input_i,
    input wire logic        positive_array_ground_switch_o,
    input wire logic        negative_array_ground_switch_o,
    input wire logic        array_to_inputs_o,
    input wire logic [15:0] dac_bits_o,
    input wire logic        quarter_bw_o,
    input wire logic [15:0] result_o,
    input wire logic        busy_o,
    input wire logic        result_valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_start_busy: assert property (
        $rose(conversion_start_input_i) && !busy_o |-> ##3 busy_o) else $error("late busy");
    a_switch_order: assert property (
        $rose(busy_o) |-> !positive_array_ground_switch_o && !negative_array_ground_switch_o
        && array_to_inputs_o ##1 !array_to_inputs_o) else $error("switch order");
    a_msb_trial: assert property (
        $rose(busy_o) |-> ##2 dac_bits_o == 16'h8000) else $error("msb trial");
    a_back_acq: assert property (
        $fell(busy_o) |-> result_valid_o && positive_array_ground_switch_o
        && negative_array_ground_switch_o && array_to_inputs_o && dac_bits_o == 16'h0000)
        else $error("no acquisition");
    a_bw_frozen: assert property (
        busy_o && $past(busy_o) |-> $stable(quarter_bw_o)) else $error("bw moved");
    a_result_hold: assert property (
        !$fell(busy_o) |-> $stable(result_o)) else $error("result moved");
    a_conv_len: assert property (
        $rose(busy_o) |-> ##51 $fell(busy_o)) else $error("busy length");
    a_valid_clear: assert property (
        $rose(busy_o) |-> !result_valid_o) else $error("valid stuck");
endmodule

bind sar_conversion_sequencer sar_seq_checker i_chk (.clk_i, .rst_i,
    .conversion_start_input_i, .positive_array_ground_switch_o,
    .negative_array_ground_switch_o, .array_to_inputs_o, .dac_bits_o,
    .quarter_bw_o, .result_o, .busy_o, .result_valid_o);

// file: sar_defs.vh
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH

// result width and step count
`define RES_W          16
`define STEP_W         5
`define STEP_LAST      5'h0F
`define MSB_IDX        4'hF

// configuration word fields
`define CFG_W          14
`define CFG_BW_BIT     6
`define CFG_INCC_HI    12
`define CFG_INCC_LO    10
`define INCC_UNI_GND   3'h7
`define INCC_UNI_COM   3'h6
`define INCC_BIP_COM   3'h2

// end codes
`define UNI_MIN        16'h0000
`define UNI_MAX        16'hFFFF
`define BIP_MIN        16'h8000
`define BIP_MAX        16'h7FFF
`define SIGN_FLIP      16'h8000

// switch settling, in internal clock cycles
`define GND_OPEN_CYC   2'h1
`define HOLD_CYC       2'h1
`define WAIT_LAST      2'h1
// one trial: pattern out, then two comparator sync flops
`define TRIAL_CYC      2'h3

`endif

// file: sar_front_model.sv
module sar_front_model (
    // trial pattern and held sample
    input  wire logic [15:0] dac_bits_i,
    input  wire logic [15:0] level_i,
    // decision back to the sequencer
    output logic             comparator_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign comparator_o = (level_i >= dac_bits_i);
endmodule

// file: tb_sar_conversion_sequencer.sv
module tb_sar_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [13:0] cfg;
        logic [15:0] lvl;
        logic        ov;
        logic        un;
        logic [15:0] exp;
    } row_t;
    logic        clk_i = 0, rst_i = 1, conversion_start_input_i = 0, ov = 0, un = 0, comp;
    logic [13:0] cfg_word_i = 14'h1C00;
    logic [15:0] lvl = 16'h0000, dac_bits_o, result_o;
    logic        positive_array_ground_switch_o, negative_array_ground_switch_o;
    logic        array_to_inputs_o, quarter_bw_o, busy_o, result_valid_o;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    row_t rows[10] = '{'{14'h1C00, 16'h0000, 0, 0, 16'h0000}, '{14'h1840, 16'h8000, 0, 0, 16'h8000},
        '{14'h1400, 16'hFFFF, 0, 0, 16'hFFFF}, '{14'h0800, 16'h0000, 0, 0, 16'h8000},
        '{14'h0440, 16'h8000, 0, 0, 16'h0000}, '{14'h0000, 16'hFFFF, 0, 0, 16'h7FFF},
        '{14'h1C00, 16'h1234, 1, 0, 16'hFFFF}, '{14'h1C00, 16'h1234, 0, 1, 16'h0000},
        '{14'h0800, 16'h1234, 1, 0, 16'h7FFF}, '{14'h0800, 16'h1234, 0, 1, 16'h8000}};
    sar_conversion_sequencer i_dut (.clk_i, .rst_i, .conversion_start_input_i, .cfg_word_i,
        .comparator_i(comp), .over_range_i(ov), .under_range_i(un),
        .positive_array_ground_switch_o, .negative_array_ground_switch_o, .array_to_inputs_o,
        .dac_bits_o, .quarter_bw_o, .result_o, .busy_o, .result_valid_o);
    sar_front_model i_front (.dac_bits_i(dac_bits_o), .level_i(lvl), .comparator_o(comp));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl_w);
        int n;
        n = 0;
        while (busy_o !== lvl_w && n < 80) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    task automatic convert(input row_t r, input logic nudge);
        @(posedge clk_i);
        {cfg_word_i, lvl, ov, un} <= {r.cfg, r.lvl, r.ov, r.un};
        repeat (3) @(posedge clk_i);
        #1 check(quarter_bw_o, r.cfg[6]);
        // quarter bandwidth: host stretches acquisition by 150 cycles, period 209 cycles instead of 59
        if (r.cfg[6]) repeat (150) @(posedge clk_i);
        @(posedge clk_i) conversion_start_input_i <= 1;
        wait_busy(1);
        @(posedge clk_i) conversion_start_input_i <= 0;
        // extra start while busy must be ignored
        if (nudge) repeat (4) @(posedge clk_i) conversion_start_input_i <= ~conversion_start_input_i;
        wait_busy(0);
        check(result_o, r.exp);
        check(result_valid_o, 1);
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        foreach (rows[i]) convert(rows[i], i == 3);
        @(posedge clk_i) conversion_start_input_i <= 1;
        wait_busy(1);
        @(posedge clk_i) rst_i <= 1;
        #1 check({busy_o, result_valid_o, positive_array_ground_switch_o}, 3'h1);
        check(result_o, 16'h0000);
        stop_test();
    end
endmodule
